/* bench/conv_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module conv_core_model
  import sar_ctl_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       conv_start,
  input  wire conv_req_t  conv_req,
  input  wire logic       adc_power_on,
  input  wire logic [7:0] dly,
  output logic            conv_done,
  output logic [11:0]     conv_result
);
  logic [7:0]  cnt_r;
  logic        run_r;
  logic [11:0] last_r;
  wire  [11:0] sample = {1'b0, conv_req.channel, 8'ha5};

  // Result bus shows junk between answers so a stale sample cannot pass
  always_ff @(posedge aclk) begin
    conv_done   <= 1'b0;
    conv_result <= ~last_r;
    if (!aresetn || !adc_power_on) begin
      run_r  <= 1'b0;
      cnt_r  <= 8'h00;
      last_r <= 12'h000;
    end else if (conv_start) begin
      run_r <= 1'b1;
      cnt_r <= dly;
    end else if (run_r && cnt_r == 8'h00) begin
      run_r       <= 1'b0;
      conv_done   <= 1'b1;
      conv_result <= sample;
      last_r      <= sample;
    end else if (run_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule : conv_core_model
`default_nettype wire

/* bench/sar_adc_conversion_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control_test
  import sar_ctl_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, dly = 8'd3;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0]  wstrb = 4'h1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, conv_start, conv_done;
  logic        adc_power_on, ref_power_on, data_ready_n;
  logic [1:0]  bresp, rresp, resp_v;
  logic [11:0] conv_result;
  conv_req_t   conv_req;
  int          n_errors = 0, checks_done = 0, cycles = 0, n;
  ch_t         log_q[$];
  logic [5:0]  rst_idx[6] = '{IDX_PRIMARY, IDX_MODE, IDX_REF, IDX_STATUS, IDX_FLAGS, IDX_SCAN_EN};
  logic [31:0] rst_val[6] = '{32'h18, 32'h00, 32'h28, 32'h40, 32'h00, 32'h00};
  logic [3:0]  mode_t[5]  = '{4'h8, 4'h7, 4'h6, 4'ha, 4'hc};
  int          flag_t[5]  = '{7, 6, 5, 1, 0};
  logic [3:0]  res_t[4]   = '{4'h8, 4'ha, 4'hc, 4'hc};
  logic [4:0]  avg_t[4]   = '{5'h01, 5'h05, 5'h08, 5'h0f};
  int          ms_t[4]    = '{0, 1, 4, 8};
  ch_t         auto_t[6]  = '{CH_LEFT, CH_VBAT, CH_TEMPERATURE_SENSOR_TWO, CH_LEFT, CH_VBAT, CH_TEMPERATURE_SENSOR_TWO};

  always #2 aclk = ~aclk;

  sar_adc_conversion_control #(.SETTLE_UNIT_CYCLES(10)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .conv_start(conv_start), .conv_req(conv_req),
    .conv_done(conv_done), .conv_result(conv_result), .adc_power_on(adc_power_on),
    .ref_power_on(ref_power_on), .data_ready_n(data_ready_n));

  conv_core_model core (
    .aclk(aclk), .aresetn(aresetn), .conv_start(conv_start), .conv_req(conv_req),
    .adc_power_on(adc_power_on), .dly(dly), .conv_done(conv_done), .conv_result(conv_result));

  task automatic tally_and_finish;
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp_v = bresp;
  endtask : wr

  task automatic rd(input logic [5:0] idx);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_v   = rdata;
    resp_v = rresp;
  endtask : rd

  task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(rd_v, exp);
  endtask : rdchk

  task automatic wait_start;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (conv_start !== 1'b1);
  endtask : wait_start

  // Polls over the bus, so it also proves the idle (not busy) status is visible to software
  task automatic wait_idle;
    do rd(IDX_STATUS); while (rd_v[BUSY_BIT] !== 1'b1);
  endtask : wait_idle

  task automatic one(input logic [3:0] mode, input int c);
    wr(IDX_MODE, {2'b00, mode, INT_DAV});
    rdchk(IDX_STATUS, 32'h00);
    wait_start;
    chk(conv_req.channel, c);
    chk(ref_power_on, 1'b1);
    wait_idle;
    chk(data_ready_n, 1'b0);
    rdchk(IDX_STATUS, 32'h60);
    rdchk(IDX_FLAGS, 32'h1 << flag_t[c]);
    rdchk(IDX_RESULT0 + 6'(c), {20'h0, 1'b0, 3'(c), 8'ha5});
    rdchk(IDX_FLAGS, 32'h0);
    chk(data_ready_n, 1'b1);
    chk(ref_power_on, 1'b0);
  endtask : one

  always @(posedge aclk) begin
    cycles++;
    if (conv_start === 1'b1) log_q.push_back(conv_req.channel);
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rst_idx[i]) rdchk(rst_idx[i], rst_val[i]);
    rd(6'h01);
    chk(resp_v, RESP_SLVERR);
    wr(IDX_REF, 8'hac);
    chk(resp_v, {30'h0, RESP_OKAY});
    rdchk(IDX_REF, 32'hac);
    wr(IDX_REF, 8'h28);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_PRIMARY, {1'b0, 2'(i + 1), 2'(i), i[0], 2'(i)});
      wr(IDX_MODE, {2'b00, 4'h7, INT_OFF});
      wait_start;
      chk(conv_req.res_bits, res_t[i]);
      chk(conv_req.clk_div, 4'h1 << i);
      chk(conv_req.median, i[0]);
      chk(conv_req.avg_samples, avg_t[i]);
      chk(conv_req.ref_internal, 1'b0);
      wait_idle;
      chk(data_ready_n, 1'b1);
      rd(IDX_RESULT0 + 6'(CH_RIGHT));
    end
    foreach (mode_t[i]) one(mode_t[i], i);
    foreach (ms_t[i]) begin
      wr(IDX_REF, 8'h80 | 8'(i << 2));
      wr(IDX_MODE, {2'b00, 4'h6, INT_OFF});
      wait_start;
      chk({31'h0, n >= ms_t[i] * 10 - 3 && n <= ms_t[i] * 10 + 4}, 32'h1);
      chk(conv_req.ref_internal, 1'b1);
      wait_idle;
      rd(IDX_RESULT0 + 6'(CH_VBAT));
    end
    chk(ref_power_on, 1'b1);
    log_q.delete();
    wr(IDX_MODE, {2'b00, 4'hb, INT_DAV});
    wait_idle;
    chk(log_q.size(), 3);
    for (int i = 0; i < 3; i++) chk(log_q[i], i);
    rdchk(IDX_FLAGS, 32'he0);
    for (int i = 0; i < 3; i++) rd(IDX_RESULT0 + 6'(i));
    // Slow core answers here so the stop lands in mid-conversion
    log_q.delete();
    dly <= 8'd40;
    wr(IDX_SCAN_EN, 8'hb8);
    wr(IDX_MODE, {2'b00, 4'h9, INT_DAV});
    while (log_q.size() < 7) @(posedge aclk);
    wr(IDX_PRIMARY, 8'h98);
    repeat (2) @(posedge aclk);
    chk(adc_power_on, 1'b0);
    chk(data_ready_n, 1'b1);
    foreach (auto_t[i]) chk(log_q[i], auto_t[i]);
    rdchk(IDX_STATUS, 32'h60);
    rdchk(IDX_FLAGS, 32'ha1);
    wr(IDX_PRIMARY, 8'h18);
    repeat (2) @(posedge aclk);
    chk(adc_power_on, 1'b1);
    tally_and_finish();
  end
endmodule : sar_adc_conversion_control_test
`default_nettype wire

/* logic/sar_adc_conversion_control.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control
  import sar_ctl_pkg::*;
#(
  parameter int unsigned SETTLE_UNIT_CYCLES = CLK_KHZ * SETTLE_MS_1,
  parameter int          TIMER_W            = 24
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             conv_start,
  output conv_req_t        conv_req,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_result,
  output logic             adc_power_on,
  output logic             ref_power_on,
  output logic             data_ready_n
);
  typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_START, S_WAIT} state_t;

  state_t      state_r, state_nxt;
  logic [7:0]  primary_r, mode_r, ref_r, scan_en_r, aw_idx_r;
  logic [7:0]  wbyte_r;
  logic        aw_full_r, w_full_r, lane0_r;
  logic [4:0]  flags_r, flags_nxt;
  logic [1:0]  slot_r, slot_nxt;
  logic [11:0] result_r [5];

  // Bus handshake
  wire aw_take  = awvalid && awready;
  wire w_take   = wvalid && wready;
  wire ar_take  = arvalid && arready;
  wire do_write = aw_full_r && w_full_r && !bvalid;
  wire aw_full_nxt = (aw_full_r || aw_take) && !do_write;
  wire w_full_nxt  = (w_full_r || w_take) && !do_write;
  wire bvalid_nxt  = (bvalid && !bready) || do_write;
  wire rvalid_nxt  = (rvalid && !rready) || ar_take;
  wire [5:0] w_idx = aw_idx_r[5:0];
  wire [5:0] r_idx = araddr[7:2];
  wire w_map = (w_idx == IDX_PRIMARY) || (w_idx == IDX_MODE) || (w_idx == IDX_REF) || (w_idx == IDX_SCAN_EN);
  wire r_res = (r_idx >= IDX_RESULT0) && (r_idx <= IDX_RESULT4);
  wire r_cfg = (r_idx == IDX_PRIMARY) || (r_idx == IDX_MODE) || (r_idx == IDX_REF) || (r_idx == IDX_SCAN_EN);
  wire r_map = r_cfg || r_res || (r_idx == IDX_STATUS) || (r_idx == IDX_FLAGS);

  // Register write decode
  wire wr_primary = do_write && lane0_r && (w_idx == IDX_PRIMARY);
  wire wr_mode    = do_write && lane0_r && (w_idx == IDX_MODE);
  wire wr_ref     = do_write && lane0_r && (w_idx == IDX_REF);
  wire wr_scan    = do_write && lane0_r && (w_idx == IDX_SCAN_EN);
  wire [7:0] mode_wval = wbyte_r & MODE_WMASK;

  // Field views
  wire       stop      = primary_r[STOP_BIT];
  wire [1:0] res_code  = primary_r[RES_LSB +: 2];
  wire [1:0] div_code  = primary_r[DIV_LSB +: 2];
  wire       median    = primary_r[FILT_BIT];
  wire [1:0] avg_code  = primary_r[AVG_LSB +: 2];
  wire [3:0] mode      = mode_r[MODE_LSB +: 4];
  wire [1:0] int_code  = mode_r[INT_LSB +: 2];
  wire       ref_int   = ref_r[REFSEL_BIT];
  wire       ref_auto  = ref_r[REFPWR_BIT];
  wire [1:0] settle_cd = ref_r[SETTLE_LSB +: 2];
  wire       busy      = (state_r != S_IDLE);
  wire       irq_cond  = !stop && (int_code == INT_DAV);

  wire [3:0] res_bits =
    (res_code == 2'h1) ? 4'd8 :
    (res_code == 2'h2) ? 4'd10 : 4'd12;
  wire [3:0] clk_div = 4'h1 << div_code;
  wire [4:0] avg_mean =
    (avg_code == 2'h1) ? AVG_MEAN_1 :
    (avg_code == 2'h2) ? AVG_MEAN_2 :
    (avg_code == 2'h3) ? AVG_MEAN_3 : 5'h01;
  wire [4:0] avg_med =
    (avg_code == 2'h1) ? AVG_MED_1 :
    (avg_code == 2'h2) ? AVG_MED_2 :
    (avg_code == 2'h3) ? AVG_MED_3 : 5'h01;
  wire [4:0] avg_samples = median ? avg_med : avg_mean;

  wire [31:0] settle_ms =
    (settle_cd == 2'h1) ? SETTLE_MS_1 :
    (settle_cd == 2'h2) ? SETTLE_MS_2 :
    (settle_cd == 2'h3) ? SETTLE_MS_3 : SETTLE_MS_0;
  wire [63:0] settle_prod = 64'(settle_ms) * 64'(SETTLE_UNIT_CYCLES);
  wire [TIMER_W-1:0] settle_cycles = settle_prod[TIMER_W-1:0];

  // Slot order: left, right, battery, temperature
  wire [3:0] auto_mask = {scan_en_r[EN_TEMP_BIT], scan_en_r[EN_VBAT_BIT],
                          scan_en_r[EN_RIGHT_BIT], scan_en_r[EN_LEFT_BIT]};
  wire [3:0] slot_mask =
    (mode == MODE_AUTO)  ? auto_mask :
    (mode == MODE_SWEEP) ? 4'h7 :
    (mode == MODE_LEFT)  ? 4'h1 :
    (mode == MODE_RIGHT) ? 4'h2 :
    (mode == MODE_VBAT)  ? 4'h4 :
    ((mode == MODE_TEMPERATURE_SENSOR_ONE) || (mode == MODE_TEMPERATURE_SENSOR_TWO)) ? 4'h8 : 4'h0;
  wire temp_two = (mode == MODE_AUTO) ? scan_en_r[TEMP_SEL_BIT] : (mode == MODE_TEMPERATURE_SENSOR_TWO);
  wire repeat_scan = (mode == MODE_AUTO);

  function automatic logic [2:0] pick_slot(input logic [3:0] mask, input logic [2:0] from);
    logic [2:0] found;
    found = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (mask[i] && (3'(i) >= from)) begin
        found = {1'b1, 2'(i)};
      end
    end
    return found;
  endfunction : pick_slot

  wire [2:0] first_pick = pick_slot(slot_mask, 3'h0);
  wire [2:0] next_pick  = pick_slot(slot_mask, {1'b0, slot_r} + 3'h1);
  wire       timer_expired;

  ch_t cur_ch;
  assign cur_ch = (slot_r == 2'h0) ? CH_LEFT :
                  (slot_r == 2'h1) ? CH_RIGHT :
                  (slot_r == 2'h2) ? CH_VBAT :
                  temp_two ? CH_TEMPERATURE_SENSOR_TWO : CH_TEMPERATURE_SENSOR_ONE;

  // A new code other than MODE_NONE, or any such code while idle, restarts the sequence
  wire [3:0] new_mode = mode_wval[MODE_LSB +: 4];
  wire mode_change = wr_mode && (new_mode != mode);
  wire kick = wr_mode && (new_mode != MODE_NONE) && (mode_change || !busy);
  wire stop_now = stop || (wr_primary && wbyte_r[STOP_BIT]);
  wire settle_load = (state_nxt == S_SETTLE) && (state_r != S_SETTLE);

  always_comb begin
    state_nxt = state_r;
    slot_nxt  = slot_r;
    unique case (state_r)
      S_IDLE: begin
        state_nxt = S_IDLE;
      end
      S_SETTLE: begin
        if (timer_expired) begin
          state_nxt = S_START;
        end
      end
      S_START: begin
        state_nxt = S_WAIT;
      end
      S_WAIT: begin
        if (conv_done) begin
          if (next_pick[2]) begin
            slot_nxt  = next_pick[1:0];
            state_nxt = S_START;
          end else if (repeat_scan && first_pick[2]) begin
            slot_nxt  = first_pick[1:0];
            state_nxt = S_START;
          end else begin
            state_nxt = S_IDLE;
          end
        end
      end
    endcase
    if (kick) begin
      state_nxt = S_SETTLE;
      slot_nxt  = 2'h0;
    end
    if (mode_change && (new_mode == MODE_NONE)) begin
      state_nxt = S_IDLE;
    end
    if (stop_now) begin
      state_nxt = S_IDLE;
    end
  end

  // First slot is chosen after settling so late enables still count
  wire [1:0] slot_go = (state_r == S_SETTLE) ? first_pick[1:0] : slot_nxt;
  wire empty_scan = (state_r == S_SETTLE) && (state_nxt == S_START) && !first_pick[2];
  ch_t go_ch;
  assign go_ch = (slot_go == 2'h0) ? CH_LEFT :
                 (slot_go == 2'h1) ? CH_RIGHT :
                 (slot_go == 2'h2) ? CH_VBAT :
                 temp_two ? CH_TEMPERATURE_SENSOR_TWO : CH_TEMPERATURE_SENSOR_ONE;

  settle_timer #(.W(TIMER_W)) u_settle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (settle_load),
    .count   (settle_cycles),
    .expired (timer_expired)
  );

  // Result reads clear channel flags; a new result in the same cycle wins
  logic [4:0] set_vec, clr_vec;
  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    if ((state_r == S_WAIT) && conv_done && !stop_now) begin
      set_vec[cur_ch] = 1'b1;
    end
    if (ar_take && r_res) begin
      clr_vec[3'(r_idx - IDX_RESULT0)] = 1'b1;
    end
    flags_nxt = (flags_r & ~clr_vec) | set_vec;
  end

  wire [7:0] status_byte = {1'b0, !busy, |flags_r, 5'h00};
  wire [7:0] flags_byte  = {flags_r[CH_LEFT], flags_r[CH_RIGHT], flags_r[CH_VBAT], 3'h0,
                            flags_r[CH_TEMPERATURE_SENSOR_ONE], flags_r[CH_TEMPERATURE_SENSOR_TWO]};
  wire [7:0] reg_byte =
    (r_idx == IDX_PRIMARY) ? primary_r :
    (r_idx == IDX_MODE)    ? mode_r :
    (r_idx == IDX_REF)     ? ref_r :
    (r_idx == IDX_SCAN_EN) ? scan_en_r :
    (r_idx == IDX_STATUS)  ? status_byte :
    (r_idx == IDX_FLAGS)   ? flags_byte : 8'h00;
  wire [31:0] rd_word = r_res ? {20'h0, result_r[3'(r_idx - IDX_RESULT0)]} : {24'h0, reg_byte};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rresp     <= RESP_OKAY;
      rdata     <= '0;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_idx_r  <= '0;
      wbyte_r   <= '0;
    end else begin
      awready   <= !aw_full_nxt && !bvalid_nxt;
      wready    <= !w_full_nxt && !bvalid_nxt;
      arready   <= !rvalid_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      bvalid    <= bvalid_nxt;
      rvalid    <= rvalid_nxt;
      if (aw_take) begin
        aw_idx_r <= {2'h0, awaddr[7:2]};
      end
      if (w_take) begin
        wbyte_r <= wstrb[0] ? wdata[7:0] : 8'h00;
      end
      if (do_write) begin
        bresp <= w_map ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_take) begin
        rdata <= rd_word;
        rresp <= r_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Byte lane 0 missing means the write leaves the register unchanged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane0_r <= 1'b0;
    end else if (w_take) begin
      lane0_r <= wstrb[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primary_r <= PRIMARY_RST;
      mode_r    <= MODE_RST;
      ref_r     <= REF_RST;
      scan_en_r <= SCAN_RST;
    end else if (lane0_r) begin
      if (wr_primary) primary_r <= wbyte_r;
      if (wr_mode)    mode_r    <= mode_wval;
      if (wr_ref)     ref_r     <= wbyte_r & REF_WMASK;
      if (wr_scan)    scan_en_r <= wbyte_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r      <= S_IDLE;
      slot_r       <= '0;
      flags_r      <= '0;
      conv_start   <= 1'b0;
      conv_req     <= '0;
      adc_power_on <= 1'b0;
      ref_power_on <= 1'b0;
      data_ready_n <= 1'b1;
    end else begin
      state_r      <= empty_scan ? S_IDLE : state_nxt;
      slot_r       <= slot_go;
      flags_r      <= flags_nxt;
      conv_start   <= (state_nxt == S_START) && !empty_scan;
      if (state_nxt == S_START) begin
        conv_req <= '{channel: go_ch, res_bits: res_bits, clk_div: clk_div,
                      median: median, avg_samples: avg_samples, ref_internal: ref_int};
      end
      adc_power_on <= !stop_now;
      // Auto reference power saves current between scans at the cost of settling time
      ref_power_on <= !stop_now && (!ref_auto || (state_nxt != S_IDLE));
      data_ready_n <= !(irq_cond && |flags_nxt);
    end
  end

  always_ff @(posedge aclk) begin
    if ((state_r == S_WAIT) && conv_done) begin
      result_r[cur_ch] <= conv_result;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stop_aborts: assert property (stop |=> !busy && !conv_start)
    else $error("stop did not abort conversion");
  a_stop_powers: assert property (stop |=> !adc_power_on && !ref_power_on)
    else $error("stop did not power down");
  a_ref_forever: assert property (!stop && !ref_auto && !wr_primary |=> ref_power_on)
    else $error("reference not held powered");
  a_busy_read: assert property (ar_take && r_idx == IDX_STATUS |=> rdata[BUSY_BIT] == !$past(busy))
    else $error("busy flag readback wrong");
  a_flag_sets: assert property (state_r == S_WAIT && conv_done && !stop_now |=> flags_r != 5'h00)
    else $error("result did not raise a flag");
  a_flag_holds: assert property (flags_r[CH_LEFT] && !clr_vec[CH_LEFT] |=> flags_r[CH_LEFT])
    else $error("left flag cleared without read");
  a_irq_pending: assert property ((|flags_r) && $past(irq_cond) |-> !data_ready_n)
    else $error("interrupt not asserted with pending data");
  a_irq_gated: assert property (!$past(irq_cond) |-> data_ready_n)
    else $error("interrupt asserted while disabled or stopped");
  a_scan_loops: assert property (state_r == S_WAIT && conv_done && repeat_scan && first_pick[2]
                                 && !stop_now && !wr_mode |=> state_r == S_START)
    else $error("auto scan did not continue");
  a_res_issued: assert property (conv_start |-> conv_req.res_bits == $past(res_bits))
    else $error("resolution not passed to converter");
  a_settle_first: assert property (state_r == S_SETTLE && !timer_expired |=> !conv_start)
    else $error("conversion started before settling");
endmodule : sar_adc_conversion_control
`default_nettype wire

/* logic/sar_ctl_pkg.sv */
package sar_ctl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PRIMARY   = 6'h02;
  localparam logic [5:0] IDX_MODE      = 6'h03;
  localparam logic [5:0] IDX_REF       = 6'h06;
  localparam logic [5:0] IDX_STATUS    = 6'h09;
  localparam logic [5:0] IDX_FLAGS     = 6'h0a;
  localparam logic [5:0] IDX_SCAN_EN   = 6'h13;
  localparam logic [5:0] IDX_RESULT0   = 6'h30;
  localparam logic [5:0] IDX_RESULT4   = 6'h34;

  // Primary control fields
  localparam int STOP_BIT   = 7;
  localparam int RES_LSB    = 5;
  localparam int DIV_LSB    = 3;
  localparam int FILT_BIT   = 2;
  localparam int AVG_LSB    = 0;
  // Mode register fields
  localparam int MODE_LSB   = 2;
  localparam int INT_LSB    = 0;
  // Reference control fields
  localparam int REFSEL_BIT = 7;
  localparam int REFPWR_BIT = 5;
  localparam int SETTLE_LSB = 2;
  // Status fields
  localparam int BUSY_BIT   = 6;
  localparam int DAV_BIT    = 5;
  // Scan enable fields
  localparam int EN_LEFT_BIT  = 7;
  localparam int EN_RIGHT_BIT = 6;
  localparam int EN_VBAT_BIT  = 5;
  localparam int EN_TEMP_BIT  = 4;
  localparam int TEMP_SEL_BIT = 3;

  localparam logic [7:0] PRIMARY_RST = 8'h18;
  localparam logic [7:0] MODE_RST    = 8'h00;
  localparam logic [7:0] REF_RST     = 8'h28;
  localparam logic [7:0] SCAN_RST    = 8'h00;
  localparam logic [7:0] MODE_WMASK  = 8'h3f;
  localparam logic [7:0] REF_WMASK   = 8'hac;

  localparam logic [3:0] MODE_NONE   = 4'h0;
  localparam logic [3:0] MODE_VBAT   = 4'h6;
  localparam logic [3:0] MODE_RIGHT  = 4'h7;
  localparam logic [3:0] MODE_LEFT   = 4'h8;
  localparam logic [3:0] MODE_AUTO   = 4'h9;
  localparam logic [3:0] MODE_TEMPERATURE_SENSOR_ONE  = 4'ha;
  localparam logic [3:0] MODE_SWEEP  = 4'hb;
  localparam logic [3:0] MODE_TEMPERATURE_SENSOR_TWO  = 4'hc;
  localparam logic [1:0] INT_OFF     = 2'h0;
  localparam logic [1:0] INT_DAV     = 2'h1;

  // Reference settling times in ms, and the clock rate in kHz
  localparam int unsigned SETTLE_MS_0 = 0;
  localparam int unsigned SETTLE_MS_1 = 1;
  localparam int unsigned SETTLE_MS_2 = 4;
  localparam int unsigned SETTLE_MS_3 = 8;
  localparam int unsigned CLK_KHZ     = 250000;

  localparam logic [4:0] AVG_MEAN_1   = 5'h04;
  localparam logic [4:0] AVG_MEAN_2   = 5'h08;
  localparam logic [4:0] AVG_MEAN_3   = 5'h10;
  localparam logic [4:0] AVG_MED_1    = 5'h05;
  localparam logic [4:0] AVG_MED_2    = 5'h09;
  localparam logic [4:0] AVG_MED_3    = 5'h0f;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {CH_LEFT, CH_RIGHT, CH_VBAT, CH_TEMPERATURE_SENSOR_ONE, CH_TEMPERATURE_SENSOR_TWO} ch_t;

  typedef struct packed {
    ch_t        channel;
    logic [3:0] res_bits;
    logic [3:0] clk_div;
    logic       median;
    logic [4:0] avg_samples;
    logic       ref_internal;
  } conv_req_t;

endpackage : sar_ctl_pkg

/* logic/settle_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module settle_timer #(
  parameter int W = 24
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              expired
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign expired = (cnt_r == '0) && !load;
endmodule : settle_timer
`default_nettype wire
